// File: verif/baud_rate_timer_properties.sv
// Concurrent checks on the baud rate timer ports.
// Assumes it is bound to baud_rate_timer; one clock, synchronous reset.
module baud_rate_timer_properties (
   // Clock and reset
   input wire logic       ref_clk_in,
   input wire logic       srst_in,
   // Controls
   input wire logic       sync_mode_in,
   input wire logic       divisor_low_wr_in,
   input wire logic [7:0] divisor_wdata_in,
   input wire logic       autobaud_enable_clr_in,
   input wire logic       wake_on_break_enable_set_in,
   input wire logic       wake_on_break_enable_clr_in,
   input wire logic       serial_receive_line_in,
   input wire logic       receive_data_read_in,
   // Observed outputs
   input wire logic [7:0] divisor_low_byte_out,
   input wire logic       autobaud_enable_out,
   input wire logic       wake_on_break_enable_out,
   input wire logic       receive_interrupt_flag_out,
   input wire logic       receiver_hold_idle_out,
   input wire logic       rate_tick_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   AST_LOW_WRITE: assert property (divisor_low_wr_in && !receiver_hold_idle_out |=>
      divisor_low_byte_out == $past(divisor_wdata_in)) else $error("divisor low byte not taken");
   AST_WRITE_RESTARTS: assert property (divisor_low_wr_in |=> ##1 !rate_tick_out [*2])
      else $error("rate tick right after divisor write");
   AST_TICK_SPACING: assert property (rate_tick_out |=> !rate_tick_out [*3])
      else $error("rate ticks closer than fastest base clock");
   AST_DONE_FLAGS: assert property ($fell(autobaud_enable_out) && !$past(autobaud_enable_clr_in) |->
      receive_interrupt_flag_out && !receiver_hold_idle_out) else $error("auto-baud end without flag");
   AST_MEASURE_HOLD: assert property ($rose(autobaud_enable_out) |=> receiver_hold_idle_out)
      else $error("receiver not held during auto-baud");
   AST_WAKE_HOLD: assert property (wake_on_break_enable_out |-> receiver_hold_idle_out)
      else $error("receiver not held while wake armed");
   AST_WAKE_SYNC: assert property (sync_mode_in && wake_on_break_enable_set_in && !wake_on_break_enable_out
      |=> !wake_on_break_enable_out) else $error("wake armed in synchronous mode");
   AST_WAKE_CLEAR: assert property ($fell(wake_on_break_enable_out) && !$past(wake_on_break_enable_clr_in)
      |-> serial_receive_line_in) else $error("wake enable cleared while line low");
   AST_FLAG_STANDS: assert property (receive_interrupt_flag_out && !receive_data_read_in
      |=> receive_interrupt_flag_out) else $error("receive flag dropped without read");
endmodule : baud_rate_timer_properties

bind baud_rate_timer baud_rate_timer_properties u_baud_rate_timer_properties (.ref_clk_in, .srst_in,
   .sync_mode_in, .divisor_low_wr_in, .divisor_wdata_in, .autobaud_enable_clr_in, .wake_on_break_enable_set_in,
   .wake_on_break_enable_clr_in, .serial_receive_line_in, .receive_data_read_in, .divisor_low_byte_out,
   .autobaud_enable_out, .wake_on_break_enable_out, .receive_interrupt_flag_out, .receiver_hold_idle_out,
   .rate_tick_out);

// File: verif/remote_tx.sv
// Remote asynchronous transmitter driving the receive line.
// Assumes bit times are whole system clock cycles; idle mark is high.
module remote_tx (
   // Clock
   input  wire logic ref_clk_in,
   // Serial line
   output logic      line_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Line rests at the mark level between frames
   initial line_out = 1'b1;

   // Break: caller passes ten or more bit times of low
   task automatic send_low(input int cycles);
      line_out = 1'b0;
      repeat (cycles) @(negedge ref_clk_in);
      line_out = 1'b1;
   endtask : send_low

   // Start bit, eight data bits LSB first, stop bit
   task automatic send_frame(input logic [7:0] data, input int bit_cycles);
      logic [9:0] f;
      f = {1'b1, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out = f[i];
         repeat (bit_cycles) @(negedge ref_clk_in);
      end
   endtask : send_frame
endmodule : remote_tx

// File: verif/testbench.sv
// Self-checking bench for the baud rate timer.
// Assumes remote_tx drives the line; inputs change on falling edges.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic       ref_clk_in, srst_in, sync_mode_in, wide_divider_select_in, high_speed_select_in;
   logic       divisor_low_wr_in, divisor_high_wr_in, autobaud_enable_set_in, autobaud_enable_clr_in;
   logic       autobaud_overflow_clr_in, wake_on_break_enable_set_in, wake_on_break_enable_clr_in;
   logic       serial_receive_line_in, rx_char_done_in, rx_shifter_idle_in, receive_data_read_in;
   logic [7:0] divisor_wdata_in, divisor_low_byte_out, divisor_high_byte_out;
   logic       autobaud_enable_out, autobaud_overflow_flag_out, wake_on_break_enable_out;
   logic       receive_interrupt_flag_out, receiver_idle_flag_out, receiver_hold_idle_out, rate_tick_out;
   int         fail_count = 0;
   int         n_tests = 0;
   int         cycles = 0;

   baud_rate_timer u_baud_rate_timer (.*);
   remote_tx u_remote_tx (.ref_clk_in, .line_out(serial_receive_line_in));

   // Free-running system clock
   initial begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   // Run ceiling well above the longest expected sequence
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         $display("[ERR] timeout expected 0 seen %0d", cycles);
         test_done();
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One-cycle control pulse: 0 auto-baud set, 1 auto-baud clear, 2 wake set, 3 data read,
   // 4 overflow clear, 5 character done from the outside receiver
   task automatic pulse(input int k);
      @(negedge ref_clk_in);
      case (k)
         0: autobaud_enable_set_in = 1'b1;
         1: autobaud_enable_clr_in = 1'b1;
         2: wake_on_break_enable_set_in = 1'b1;
         3: receive_data_read_in = 1'b1;
         4: autobaud_overflow_clr_in = 1'b1;
         default: rx_char_done_in = 1'b1;
      endcase
      @(negedge ref_clk_in);
      {autobaud_enable_set_in, autobaud_enable_clr_in, wake_on_break_enable_set_in, receive_data_read_in} = 4'h0;
      {autobaud_overflow_clr_in, rx_char_done_in} = 2'h0;
   endtask : pulse

   task automatic wr(input logic hi, input logic [7:0] v);
      @(negedge ref_clk_in);
      divisor_high_wr_in = hi;
      divisor_low_wr_in = ~hi;
      divisor_wdata_in = v;
      @(negedge ref_clk_in);
      divisor_high_wr_in = 1'b0;
      divisor_low_wr_in = 1'b0;
      check("divisor byte", {8'h00, v}, {8'h00, hi ? divisor_high_byte_out : divisor_low_byte_out});
   endtask : wr

   // Rate tick spacing after a divisor write, for one selection
   task automatic t_period(input logic [1:0] sel, input logic syn, input logic [7:0] hi, input int exp);
      int n;
      {wide_divider_select_in, high_speed_select_in} = sel;
      sync_mode_in = syn;
      wr(1'b1, hi);
      wr(1'b0, 8'h03);
      n = 0;
      while (rate_tick_out !== 1'b1 && n < 6000) begin
         @(negedge ref_clk_in);
         n++;
      end
      check("first tick in range", 16'h1, 16'(n >= exp - 2 && n <= exp + 4));
      n = 0;
      do begin
         @(negedge ref_clk_in);
         n++;
      end while (rate_tick_out !== 1'b1 && n < 6000);
      check("tick period", 16'(exp), 16'(n));
      $display("test period sel %b sync %b done", sel, syn);
   endtask : t_period

   // Wake on break, then auto-baud on the following sync character
   task automatic t_wake_baud;
      {wide_divider_select_in, high_speed_select_in, sync_mode_in} = 3'b110;
      check("idle before wake", 16'h1, {15'h0, receiver_idle_flag_out});
      pulse(2);
      pulse(0);
      check("hold idle", 16'h1, {15'h0, receiver_hold_idle_out});
      fork
         u_remote_tx.send_low(13 * 64);
         begin
            repeat (20) @(negedge ref_clk_in);
            check("wake flag", 16'h1, {15'h0, receive_interrupt_flag_out});
         end
      join
      repeat (8) @(negedge ref_clk_in);
      check("wake enable", 16'h0, {15'h0, wake_on_break_enable_out});
      check("auto-baud armed", 16'h1, {15'h0, autobaud_enable_out});
      pulse(3);
      check("flag after read", 16'h0, {15'h0, receive_interrupt_flag_out});
      fork
         u_remote_tx.send_frame(8'h55, 64);
         begin
            repeat (300) @(negedge ref_clk_in);
            check("idle during count", 16'h0, {15'h0, receiver_idle_flag_out});
            check("hold during count", 16'h1, {15'h0, receiver_hold_idle_out});
         end
      join
      check("measured pair", 16'd17, {divisor_high_byte_out, divisor_low_byte_out});
      check("enable cleared", 16'h0, {15'h0, autobaud_enable_out});
      check("done flag", 16'h1, {15'h0, receive_interrupt_flag_out});
      check("hold released", 16'h0, {15'h0, receiver_hold_idle_out});
      check("idle after fifth rise", 16'h1, {15'h0, receiver_idle_flag_out});
      check("no overflow", 16'h0, {15'h0, autobaud_overflow_flag_out});
      pulse(3);
      check("flag read clear", 16'h0, {15'h0, receive_interrupt_flag_out});
      check("idle before overflow clear", 16'h1, {15'h0, receiver_idle_flag_out});
      pulse(4);
      check("overflow cleared", 16'h0, {15'h0, autobaud_overflow_flag_out});
      pulse(5);
      check("char flag after release", 16'h1, {15'h0, receive_interrupt_flag_out});
      pulse(3);
      $display("test wake and auto-baud done");
   endtask : t_wake_baud

   // Refusals: wake in synchronous mode, early auto-baud abort
   task automatic t_refuse;
      sync_mode_in = 1'b1;
      pulse(2);
      check("sync wake", 16'h0, {15'h0, wake_on_break_enable_out});
      sync_mode_in = 1'b0;
      pulse(0);
      pulse(5);
      check("char done held off", 16'h0, {15'h0, receive_interrupt_flag_out});
      pulse(1);
      repeat (2) @(negedge ref_clk_in);
      check("abort hold", 16'h0, {15'h0, receiver_hold_idle_out});
      $display("test refusals done");
   endtask : t_refuse

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // Main sequence
   initial begin
      {srst_in, rx_shifter_idle_in} = 2'b11;
      {sync_mode_in, wide_divider_select_in, high_speed_select_in, divisor_low_wr_in, divisor_high_wr_in} = 5'h0;
      {autobaud_enable_set_in, autobaud_enable_clr_in, autobaud_overflow_clr_in} = 3'h0;
      {wake_on_break_enable_set_in, wake_on_break_enable_clr_in, rx_char_done_in, receive_data_read_in} = 4'h0;
      divisor_wdata_in = 8'h00;
      repeat (8) @(negedge ref_clk_in);
      srst_in = 1'b0;
      check("reset pair", 16'h0, {divisor_high_byte_out, divisor_low_byte_out});
      check("reset flags", 16'h0, {13'h0, autobaud_enable_out, wake_on_break_enable_out, receive_interrupt_flag_out});
      t_period(2'b00, 1'b0, 8'h01, 256);
      t_period(2'b01, 1'b0, 8'h01, 64);
      t_period(2'b10, 1'b0, 8'h00, 64);
      t_period(2'b11, 1'b0, 8'h00, 16);
      t_period(2'b01, 1'b1, 8'h00, 256);
      t_period(2'b10, 1'b0, 8'h01, 4160);
      t_refuse();
      t_wake_baud();
      test_done();
   end
endmodule : testbench

// File: verilog/baud_pkg.sv
// Constants for the baud rate timer, auto-baud measurement and wake-on-break.
// Assumes one system clock (Fosc) and synchronous active-high reset.
// Behaviour
// - Eight-bit divisor by default, sixteen when wide
// - Divisor pair sets period; sync mode ignores speed
// - Base clock Fosc/64, /16 or /4
// - Measurement clock is base clock divided by eight
// - Divisor write clears the baud timer at once
// - Auto-baud enable starts measurement, receiver held idle
// - Count from first rise after start to fifth
// - Fifth rise: keep count, clear enable, set flag
// - Measurement uses full sixteen-bit pair always
// - Measurement count starts at one
// - With wake enabled, measure character after break
// - Counter overflow sets overflow and receive flags
// - Keep counting after overflow; idle low until fifth
// - Early enable clear lets edges act as starts
// - Wake enable holds port idle, watches falling edge
// - Wake event sets receive flag; read clears it
// - Wake enable clears on rising edge after break
// - Nonzero character: first low time is wake event
package baud_pkg;

   // Fosc divide ratios of the base clock, and base ticks per measure tick
   localparam int BASE_DIV_SLOW = 64;
   localparam int BASE_DIV_MID  = 16;
   localparam int BASE_DIV_FAST = 4;
   localparam int MEASURE_RATIO = 8;

   localparam logic [5:0] PRE_LIMIT_SLOW = 6'(BASE_DIV_SLOW - 1);
   localparam logic [5:0] PRE_LIMIT_MID  = 6'(BASE_DIV_MID - 1);
   localparam logic [5:0] PRE_LIMIT_FAST = 6'(BASE_DIV_FAST - 1);
   localparam logic [2:0] MEASURE_LIMIT  = 3'(MEASURE_RATIO - 1);

   // Reset values and measurement constants
   localparam logic [7:0]  DIVISOR_LOW_RST  = 8'h00;
   localparam logic [7:0]  DIVISOR_HIGH_RST = 8'h00;
   localparam logic [15:0] MEASURE_START    = 16'h0001;
   localparam logic [15:0] MEASURE_MAX      = 16'hffff;
   localparam logic [2:0]  RISES_PER_SYNC   = 3'h5;

   // Auto-baud sequencer states
   typedef enum logic [3:0] {
      AB_IDLE  = 4'b0001,
      AB_START = 4'b0010,
      AB_FIRST = 4'b0100,
      AB_COUNT = 4'b1000
   } abd_state_t;

endpackage : baud_pkg

// File: verilog/baud_rate_timer.sv
// Baud rate timer with auto-baud measurement and wake-on-break detect.
// Assumes the receive shifter sits outside and obeys the hold-idle output;
// software bits arrive as one-cycle set/clear pulses on the system clock.
module baud_rate_timer (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        srst_in,
   // Mode bits
   input  wire logic        sync_mode_in,
   input  wire logic        wide_divider_select_in,
   input  wire logic        high_speed_select_in,
   // Divisor register pair access
   input  wire logic        divisor_low_wr_in,
   input  wire logic        divisor_high_wr_in,
   input  wire logic [7:0]  divisor_wdata_in,
   output logic      [7:0]  divisor_low_byte_out,
   output logic      [7:0]  divisor_high_byte_out,
   // Control and status bits
   input  wire logic        autobaud_enable_set_in,
   input  wire logic        autobaud_enable_clr_in,
   output logic             autobaud_enable_out,
   input  wire logic        autobaud_overflow_clr_in,
   output logic             autobaud_overflow_flag_out,
   input  wire logic        wake_on_break_enable_set_in,
   input  wire logic        wake_on_break_enable_clr_in,
   output logic             wake_on_break_enable_out,
   // Receiver side
   input  wire logic        serial_receive_line_in,
   input  wire logic        rx_char_done_in,
   input  wire logic        rx_shifter_idle_in,
   input  wire logic        receive_data_read_in,
   output logic             receive_interrupt_flag_out,
   output logic             receiver_idle_flag_out,
   output logic             receiver_hold_idle_out,
   output logic             rate_tick_out
);
   import baud_pkg::*;

   prescale_if pre ();

   logic        rx_meta;
   logic        rx_sync;
   logic        rx_prev;
   logic        rx_fall;
   logic        rx_rise;
   logic [7:0]  divisor_low;
   logic [7:0]  divisor_high;
   logic [15:0] timer_count;
   logic [15:0] period;
   logic        divisor_write;
   abd_state_t  abd_state;
   abd_state_t  next_abd_state;
   logic [2:0]  rise_count;
   logic        measuring;
   logic        abd_done;
   logic        abd_wrap;
   logic        abd_enable;
   logic        abd_overflow;
   logic        wake_enable;
   logic        wake_low;
   logic        wake_event;
   logic        wake_end;
   logic        rx_flag;
   logic        tick;

   rate_prescaler u_prescaler (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .pre        (pre.gen)
   );

   // Two-stage synchroniser for the receive pin, then an edge history stage
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= serial_receive_line_in;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end

   assign rx_fall = rx_prev && !rx_sync;
   assign rx_rise = !rx_prev && rx_sync;

   // Sync mode ignores the high-speed bit when picking the prescale
   assign pre.rate_sel = {wide_divider_select_in,
                          high_speed_select_in && !sync_mode_in};
   assign divisor_write = divisor_low_wr_in || divisor_high_wr_in;
   // Realign the prescaler as counting starts so every measure tick keeps one phase
   assign pre.restart   = divisor_write || (abd_state == AB_FIRST && rx_rise);

   // Timer period; the high byte only counts in wide mode
   assign period = wide_divider_select_in ? {divisor_high, divisor_low}
                                          : {8'h00, divisor_low};

   // Free-running baud timer, held clear while the pair is a measurement counter
   always_ff @(posedge ref_clk_in) begin
      if (srst_in || divisor_write || measuring) begin
         timer_count <= 16'h0000;
      end else if (pre.base_tick) begin
         if (timer_count >= period) begin
            timer_count <= 16'h0000;
         end else begin
            timer_count <= timer_count + 16'h0001;
         end
      end
   end

   // One tick per divisor-plus-one base periods
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         tick <= 1'b0;
      end else begin
         tick <= !divisor_write && !measuring && pre.base_tick
                 && (timer_count >= period);
      end
   end

   assign rate_tick_out = tick;

   // Measurement runs from the first rise after the start bit to the fifth
   assign measuring = (abd_state == AB_COUNT);
   // The first rise opens the window, so the fifth is the fourth seen while counting
   assign abd_done  = measuring && rx_rise && (rise_count == (RISES_PER_SYNC - 3'h2));
   assign abd_wrap  = measuring && pre.measure_tick
                      && ({divisor_high, divisor_low} == MEASURE_MAX);

   // Auto-baud sequencer; waits for the break to end when wake is armed
   always_comb begin
      next_abd_state = abd_state;
      unique case (abd_state)
         AB_IDLE: begin
            if (abd_enable && !wake_enable) begin
               next_abd_state = AB_START;
            end
         end
         AB_START: begin
            if (rx_fall) begin
               next_abd_state = AB_FIRST;
            end
         end
         AB_FIRST: begin
            if (rx_rise) begin
               next_abd_state = AB_COUNT;
            end
         end
         AB_COUNT: begin
            if (abd_done) begin
               next_abd_state = AB_IDLE;
            end
         end
      endcase
      if (!abd_enable) begin
         next_abd_state = AB_IDLE;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         abd_state <= AB_IDLE;
      end else begin
         abd_state <= next_abd_state;
      end
   end

   // Rising edges seen since counting began
   always_ff @(posedge ref_clk_in) begin
      if (srst_in || abd_state != AB_COUNT) begin
         rise_count <= 3'h0;
      end else if (rx_rise) begin
         rise_count <= rise_count + 3'h1;
      end
   end

   // Divisor pair: software writes, or the measurement counter in auto-baud
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         divisor_low  <= DIVISOR_LOW_RST;
         divisor_high <= DIVISOR_HIGH_RST;
      end else if (abd_state == AB_FIRST && rx_rise) begin
         {divisor_high, divisor_low} <= MEASURE_START;
      end else if (measuring) begin
         if (pre.measure_tick) begin   // A tick on the closing edge still counts
            {divisor_high, divisor_low} <= {divisor_high, divisor_low} + 16'h0001;
         end
      end else begin
         if (divisor_low_wr_in) begin
            divisor_low <= divisor_wdata_in;
         end
         if (divisor_high_wr_in) begin
            divisor_high <= divisor_wdata_in;
         end
      end
   end

   assign divisor_low_byte_out  = divisor_low;
   assign divisor_high_byte_out = divisor_high;

   // Auto-baud enable: hardware clears at the fifth rise; a set that lands
   // in the same cycle still wins so a new request is never dropped
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         abd_enable <= 1'b0;
      end else if (autobaud_enable_set_in) begin
         abd_enable <= 1'b1;
      end else if (autobaud_enable_clr_in || abd_done) begin
         abd_enable <= 1'b0;
      end
   end

   assign autobaud_enable_out = abd_enable;

   // Overflow flag, set wins over the software clear
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         abd_overflow <= 1'b0;
      end else if (abd_wrap) begin
         abd_overflow <= 1'b1;
      end else if (autobaud_overflow_clr_in) begin
         abd_overflow <= 1'b0;
      end
   end

   assign autobaud_overflow_flag_out = abd_overflow;

   // Wake detect: first fall is the wake event, the next rise ends the break
   assign wake_event = wake_enable && !wake_low && rx_fall;
   assign wake_end   = wake_enable && wake_low && rx_rise;

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         wake_enable <= 1'b0;
      end else if (wake_on_break_enable_set_in && !sync_mode_in) begin
         wake_enable <= 1'b1;
      end else if (wake_on_break_enable_clr_in || wake_end || sync_mode_in) begin
         wake_enable <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in || !wake_enable) begin
         wake_low <= 1'b0;
      end else if (wake_event) begin
         wake_low <= 1'b1;
      end
   end

   assign wake_on_break_enable_out = wake_enable;

   // Receive flag; any hardware set beats a data register read
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rx_flag <= 1'b0;
      end else if (abd_done || abd_wrap || wake_event) begin
         rx_flag <= 1'b1;
      end else if (rx_char_done_in && !receiver_hold_idle_out) begin
         rx_flag <= 1'b1;
      end else if (receive_data_read_in) begin
         rx_flag <= 1'b0;
      end
   end

   assign receive_interrupt_flag_out = rx_flag;

   // Receiver held idle through measurement and while wake is armed
   assign receiver_hold_idle_out = (abd_state != AB_IDLE) || wake_enable;
   assign receiver_idle_flag_out = rx_shifter_idle_in
                                   && (abd_state == AB_IDLE || abd_state == AB_START);
endmodule : baud_rate_timer

// File: verilog/prescale_if.sv
// Carries the base-clock selection and the divided rate enables between
// the top block and its prescaler. Same clock domain on both ends.
interface prescale_if;
   logic [1:0] rate_sel;     // {wide, high speed}
   logic       restart;
   logic       base_tick;
   logic       measure_tick;

   modport gen  (input rate_sel, input restart, output base_tick, output measure_tick);
   modport user (output rate_sel, output restart, input base_tick, input measure_tick);
endinterface : prescale_if

// File: verilog/rate_prescaler.sv
// Divides the system clock into the baud base-clock enable and the
// measurement enable (one eighth of the base rate).
// Assumes selection is steady while counting; restart realigns both.
module rate_prescaler (
   // Clock and reset
   input  wire logic  ref_clk_in,
   input  wire logic  srst_in,
   // Rate enables
   prescale_if.gen    pre
);
   import baud_pkg::*;

   logic [5:0] pre_count;
   logic [2:0] sub_count;
   logic [5:0] pre_limit;

   // Base divide select: 00 slow, 01/10 mid, 11 fast
   always_comb begin
      unique case (pre.rate_sel)
         2'b00:   pre_limit = PRE_LIMIT_SLOW;
         2'b11:   pre_limit = PRE_LIMIT_FAST;
         default: pre_limit = PRE_LIMIT_MID;
      endcase
   end

   // Fosc cycle counter; restart keeps a new rate from inheriting phase
   always_ff @(posedge ref_clk_in) begin
      if (srst_in || pre.restart || pre.base_tick) begin
         pre_count <= 6'h00;
      end else begin
         pre_count <= pre_count + 6'h01;
      end
   end

   // Base tick counter for the slower measurement enable
   always_ff @(posedge ref_clk_in) begin
      if (srst_in || pre.restart) begin
         sub_count <= 3'h0;
      end else if (pre.base_tick) begin
         sub_count <= sub_count + 3'h1;
      end
   end

   assign pre.base_tick    = (pre_count >= pre_limit);
   assign pre.measure_tick = pre.base_tick && (sub_count == MEASURE_LIMIT);
endmodule : rate_prescaler
